/* File: rtl/rx_guard_crc_top.sv */
`timescale 1ns/1ps
module rx_guard_crc_top import rx_guard_crc_pkg::*; #(
	parameter int ADDR_W = 10
) (
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic CE_IN,
	input wire logic HSEL_IN,
	input wire logic [ADDR_W-1:0] HADDR_IN,
	input wire logic [1:0] HTRANS_IN,
	input wire logic HWRITE_IN,
	input wire logic [2:0] HSIZE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic HREADY_IN,
	output logic HREADYOUT_OUT,
	output logic HRESP_OUT,
	output logic [31:0] HRDATA_OUT,
	input wire logic TX_END_IN,
	input wire logic RX_START_IN,
	input wire logic RX_BIT_VALID_IN,
	input wire logic RX_BIT_IN,
	input wire logic RX_COLL_IN,
	input wire logic RX_END_IN,
	input wire logic MODE_DET_VALID_IN,
	input wire proto_t MODE_DET_PROTO_IN,
	output logic [7:0] RX_BYTE_OUT,
	output logic RX_BYTE_VALID_OUT,
	output logic RX_CRC_OK_OUT,
	output logic GUARD_ACTIVE_OUT,
	output logic IRQ_OUT
);
	initial begin
		if (ADDR_W < 10) begin
			$error("ADDR_W must be at least 10");
		end
	end

	typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_PARITY} state_t;

	function automatic logic idx_is(input logic [ADDR_W-3:0] a, input logic [7:0] t);
		return a == (ADDR_W-2)'(t);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers and state
	logic [31:0] guard_cfg_reg;
	logic [31:0] crc_cfg_reg;
	logic [31:0] crc_cfg_next;
	logic [IRQ_W-1:0] irq_reg;
	logic [IRQ_W-1:0] mask_reg;
	logic auto_reg;
	logic integ_reg;
	logic crc_ok_reg;
	logic dp_wr_reg;
	logic [ADDR_W-3:0] dp_idx_reg;
	logic [31:0] hrdata_reg;
	state_t state_reg;
	logic [2:0] pos_reg;
	logic [7:0] byte_reg;
	logic par_acc_reg;
	logic coll_seen_reg;
	logic [7:0] byte_out_reg;
	logic byte_valid_reg;
	logic guard_active;
	logic guard_expired;
	logic [15:0] crc_value;

	////////////////////////////////////////////////////////////////////////////
	// config fields
	wire [GUARD_RELOAD_W-1:0] reload = guard_cfg_reg[GUARD_RELOAD_LSB +: GUARD_RELOAD_W];
	wire [GUARD_PRESC_W-1:0] presc = guard_cfg_reg[GUARD_PRESC_LSB +: GUARD_PRESC_W];
	wire [15:0] custom_preset = crc_cfg_reg[CRC_PRESET_LSB +: 16];
	wire par_type = crc_cfg_reg[PAR_TYPE_BIT];
	wire par_en = crc_cfg_reg[PAR_EN_BIT];
	wire coll_keep = crc_cfg_reg[COLL_KEEP_BIT];
	wire [2:0] slot = crc_cfg_reg[SLOT_LSB +: 3];
	wire [2:0] sel = crc_cfg_reg[SEL_LSB +: 3];
	wire crc_five = crc_cfg_reg[CRC_TYPE_BIT];
	wire crc_inv = crc_cfg_reg[CRC_INV_BIT];
	wire crc_en = crc_cfg_reg[CRC_EN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	wire [ADDR_W-3:0] ap_idx = HADDR_IN[ADDR_W-1:2];
	wire ap_take = CE_IN && HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	wire ap_read = ap_take && !HWRITE_IN;
	wire rd_clr = ap_read && idx_is(ap_idx, IDX_IRQ_STATUS);
	wire dp_wr = CE_IN && dp_wr_reg;
	wire wr_guard = dp_wr && idx_is(dp_idx_reg, IDX_GUARD_CFG);
	wire wr_crc = dp_wr && idx_is(dp_idx_reg, IDX_CRC_CFG);
	wire wr_mask = dp_wr && idx_is(dp_idx_reg, IDX_IRQ_MASK);
	wire wr_ctrl = dp_wr && idx_is(dp_idx_reg, IDX_CTRL);
	wire [31:0] status_word = {28'h0000000, state_reg != ST_IDLE, crc_ok_reg, guard_active,
		integ_reg};
	wire [31:0] rd_mux =
		idx_is(ap_idx, IDX_GUARD_CFG) ? guard_cfg_reg :
		idx_is(ap_idx, IDX_CRC_CFG) ? crc_cfg_reg :
		idx_is(ap_idx, IDX_STATUS) ? status_word :
		idx_is(ap_idx, IDX_IRQ_STATUS) ? {29'h00000000, irq_reg} :
		idx_is(ap_idx, IDX_IRQ_MASK) ? {29'h00000000, mask_reg} :
		idx_is(ap_idx, IDX_CTRL) ? {31'h00000000, auto_reg} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// receive decode
	wire det_take = CE_IN && MODE_DET_VALID_IN && auto_reg;
	wire rx_start_take = CE_IN && RX_START_IN && !guard_active;
	wire busy = (state_reg != ST_IDLE);
	wire bit_take = CE_IN && RX_BIT_VALID_IN && busy && !guard_active;
	wire data_take = bit_take && (state_reg == ST_DATA);
	wire par_take = bit_take && (state_reg == ST_PARITY);
	wire coll_now = coll_seen_reg || RX_COLL_IN;
	wire bit_val = (coll_now && !coll_keep) ? 1'b0 : RX_BIT_IN;
	wire [7:0] bit_mask = 8'h01 << pos_reg;
	wire [7:0] byte_next = bit_val ? (byte_reg | bit_mask) : (byte_reg & ~bit_mask);
	wire byte_done = data_take && (pos_reg == 3'h7);
	wire par_err = par_take && (RX_BIT_IN != (par_acc_reg ^ par_type));
	wire crc_match = crc_five ? (crc_value[4:0] == CRC5_RESIDUE) :
		crc_value == (crc_inv ? CRC16_RESIDUE_INV : CRC16_RESIDUE);
	wire frame_end = CE_IN && RX_END_IN && busy;
	wire crc_err = frame_end && crc_en && !crc_match;
	wire integ_set = par_err || crc_err;
	wire [IRQ_W-1:0] irq_ev = {guard_expired, frame_end, integ_set};
	wire [15:0] preset_sel = preset_decode(sel, custom_preset);

	////////////////////////////////////////////////////////////////////////////
	// crc config: software write, then mode detector overrides
	always_comb begin
		crc_cfg_next = crc_cfg_reg;
		if (wr_crc) begin
			crc_cfg_next = HWDATA_IN & CRC_CFG_MASK;
		end
		if (det_take) begin
			unique case (MODE_DET_PROTO_IN)
				PROTO_A: begin
					crc_cfg_next[PAR_EN_BIT] = 1'b1;
					crc_cfg_next[PAR_TYPE_BIT] = 1'b1;
					crc_cfg_next[SEL_LSB +: 3] = SEL_A;
					crc_cfg_next[CRC_INV_BIT] = 1'b0;
				end
				PROTO_B: begin
					crc_cfg_next[SEL_LSB +: 3] = SEL_B;
					crc_cfg_next[CRC_INV_BIT] = 1'b1;
					crc_cfg_next[CRC_EN_BIT] = 1'b1;
				end
				PROTO_JIS_212, PROTO_JIS_424: begin
					crc_cfg_next[SEL_LSB +: 3] = SEL_ZERO;
					crc_cfg_next[CRC_INV_BIT] = 1'b0;
					crc_cfg_next[CRC_EN_BIT] = 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus slave and software registers
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			guard_cfg_reg <= GUARD_CFG_RST;
			crc_cfg_reg <= CRC_CFG_RST;
			mask_reg <= IRQ_MASK_RST;
			auto_reg <= CTRL_AUTO_RST;
			dp_wr_reg <= 1'b0;
			dp_idx_reg <= '0;
			hrdata_reg <= 32'h00000000;
		end else if (CE_IN) begin
			dp_wr_reg <= ap_take && HWRITE_IN;
			if (ap_take) begin
				dp_idx_reg <= ap_idx;
			end
			if (ap_read) begin
				hrdata_reg <= rd_mux;
			end
			if (wr_guard) begin
				guard_cfg_reg <= HWDATA_IN & GUARD_CFG_MASK;
			end
			crc_cfg_reg <= crc_cfg_next;
			if (wr_mask) begin
				mask_reg <= HWDATA_IN[IRQ_W-1:0];
			end
			if (wr_ctrl) begin
				auto_reg <= HWDATA_IN[CTRL_AUTO_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky flags; a new event wins over a clear in irq_reg and integ_reg, receive start wins over frame end in crc_ok_reg
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			irq_reg <= '0;
			integ_reg <= 1'b0;
			crc_ok_reg <= 1'b0;
		end else if (CE_IN) begin
			irq_reg <= (rd_clr ? '0 : irq_reg) | irq_ev;
			if (integ_set) begin
				integ_reg <= 1'b1;
			end else if (rx_start_take) begin
				integ_reg <= 1'b0;
			end
			if (rx_start_take) begin
				crc_ok_reg <= 1'b0;
			end else if (frame_end) begin
				crc_ok_reg <= crc_en && crc_match;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bit assembly
	always_ff @(posedge SYS_CLK_IN) begin
		if (!RST_N_IN) begin
			state_reg <= ST_IDLE;
			pos_reg <= 3'h0;
			byte_reg <= 8'h00;
			par_acc_reg <= 1'b0;
			coll_seen_reg <= 1'b0;
			byte_out_reg <= 8'h00;
			byte_valid_reg <= 1'b0;
		end else if (CE_IN) begin
			byte_valid_reg <= byte_done;
			if (rx_start_take) begin
				state_reg <= ST_DATA;
				pos_reg <= slot;
				byte_reg <= 8'h00;
				par_acc_reg <= 1'b0;
				coll_seen_reg <= 1'b0;
			end else if (frame_end) begin
				state_reg <= ST_IDLE;
			end else if (data_take) begin
				coll_seen_reg <= coll_now;
				par_acc_reg <= par_acc_reg ^ bit_val;
				pos_reg <= pos_reg + 3'h1;
				byte_reg <= byte_done ? 8'h00 : byte_next;
				if (byte_done) begin
					byte_out_reg <= byte_next;
					state_reg <= par_en ? ST_PARITY : ST_DATA;
				end
			end else if (par_take) begin
				par_acc_reg <= 1'b0;
				state_reg <= ST_DATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// guard timer and crc engine
	rx_guard_timer #(
		.RELOAD_W(GUARD_RELOAD_W),
		.PRESC_W(GUARD_PRESC_W)
	) rx_guard_timer_inst (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.start_in(TX_END_IN),
		.reload_in(reload),
		.presc_in(presc),
		.active_out(guard_active),
		.expired_out(guard_expired)
	);

	rx_crc_unit rx_crc_unit_inst (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.ce_in(CE_IN),
		.load_in(rx_start_take),
		.preset_in(preset_sel),
		.five_in(crc_five),
		.bit_valid_in(data_take),
		.bit_in(bit_val),
		.crc_out(crc_value)
	);

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT = 1'b0;
	assign HRDATA_OUT = hrdata_reg;
	assign RX_BYTE_OUT = byte_out_reg;
	assign RX_BYTE_VALID_OUT = byte_valid_reg;
	assign RX_CRC_OK_OUT = crc_ok_reg;
	assign GUARD_ACTIVE_OUT = guard_active;
	assign IRQ_OUT = |(irq_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	property p_guard_zero;
		CE_IN && TX_END_IN && reload == '0 |=> !guard_active;
	endproperty
	a_guard_zero: assert property (p_guard_zero) else $error("zero reload started guard");

	property p_guard_start;
		CE_IN && TX_END_IN && reload != '0 |=> guard_active && !rx_start_take;
	endproperty
	a_guard_start: assert property (p_guard_start) else $error("guard not started");

	property p_guard_block;
		guard_active && RX_BIT_VALID_IN |=> $stable(pos_reg) && $stable(byte_reg);
	endproperty
	a_guard_block: assert property (p_guard_block) else $error("bit taken during guard");

	property p_parity_err;
		par_take && (RX_BIT_IN == (par_acc_reg ~^ par_type)) |=> integ_reg && state_reg != ST_IDLE;
	endproperty
	a_parity_err: assert property (p_parity_err) else $error("parity error missed");

	property p_integ_clear;
		rx_start_take && !integ_set |=> !integ_reg;
	endproperty
	a_integ_clear: assert property (p_integ_clear) else $error("integrity flag not cleared");

	property p_align;
		rx_start_take |=> pos_reg == $past(slot) && state_reg == ST_DATA;
	endproperty
	a_align: assert property (p_align) else $error("first bit slot wrong");

	property p_preset_a;
		rx_start_take && sel == SEL_A && !crc_five |=> crc_value == PRESET_A;
	endproperty
	a_preset_a: assert property (p_preset_a) else $error("type A preset wrong");

	property p_short_preset;
		rx_start_take && crc_five |=> crc_value[15:8] == 8'h00;
	endproperty
	a_short_preset: assert property (p_short_preset) else $error("5-bit preset high byte");

	property p_detect_a;
		det_take && MODE_DET_PROTO_IN == PROTO_A && !wr_crc ##1 CE_IN
			|-> par_en && par_type && sel == SEL_A && !crc_inv;
	endproperty
	a_detect_a: assert property (p_detect_a) else $error("type A detection fields");

	property p_detect_b;
		det_take && MODE_DET_PROTO_IN == PROTO_B |=> sel == SEL_B && crc_inv && crc_en;
	endproperty
	a_detect_b: assert property (p_detect_b) else $error("type B detection fields");

	property p_crc_err;
		crc_err |=> integ_reg && !crc_ok_reg;
	endproperty
	a_crc_err: assert property (p_crc_err) else $error("crc error not flagged");

	c_parity_err: cover property (par_err);
	c_crc_good: cover property (frame_end && crc_en && crc_match);
	c_guard_done: cover property (guard_active ##1 !guard_active);
	c_detect_b: cover property (det_take && MODE_DET_PROTO_IN == PROTO_B);
endmodule

/* File: rtl/rx_guard_crc_pkg.sv */
package rx_guard_crc_pkg;
	////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_GUARD_CFG = 8'h11;
	localparam logic [7:0] IDX_CRC_CFG = 8'h12;
	localparam logic [7:0] IDX_STATUS = 8'h20;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
	localparam logic [7:0] IDX_CTRL = 8'h23;
	////////////////////////////////////////////////////////////////////////////
	// guard config fields
	localparam int GUARD_RELOAD_LSB = 8;
	localparam int GUARD_RELOAD_W = 20;
	localparam int GUARD_PRESC_LSB = 0;
	localparam int GUARD_PRESC_W = 8;
	localparam logic [31:0] GUARD_CFG_MASK = 32'h0FFFFFFF;
	localparam logic [31:0] GUARD_CFG_RST = 32'h00000000;
	////////////////////////////////////////////////////////////////////////////
	// crc config fields
	localparam int CRC_PRESET_LSB = 16;
	localparam int PAR_TYPE_BIT = 11;
	localparam int PAR_EN_BIT = 10;
	localparam int COLL_KEEP_BIT = 9;
	localparam int SLOT_LSB = 6;
	localparam int SEL_LSB = 3;
	localparam int CRC_TYPE_BIT = 2;
	localparam int CRC_INV_BIT = 1;
	localparam int CRC_EN_BIT = 0;
	localparam logic [31:0] CRC_CFG_MASK = 32'hFFFF0FFF;
	localparam logic [31:0] CRC_CFG_RST = 32'h00000000;
	////////////////////////////////////////////////////////////////////////////
	// own status, interrupt and control bits
	localparam int STAT_INTEG = 0;
	localparam int STAT_GUARD = 1;
	localparam int STAT_CRC_OK = 2;
	localparam int STAT_BUSY = 3;
	localparam int IRQ_INTEG = 0;
	localparam int IRQ_FRAME = 1;
	localparam int IRQ_GUARD = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam int CTRL_AUTO_BIT = 0;
	localparam logic CTRL_AUTO_RST = 1'b0;
	////////////////////////////////////////////////////////////////////////////
	// crc presets and polynomials
	localparam logic [2:0] SEL_ZERO = 3'h0;
	localparam logic [2:0] SEL_A = 3'h1;
	localparam logic [2:0] SEL_ALT = 3'h2;
	localparam logic [2:0] SEL_B = 3'h3;
	localparam logic [2:0] SEL_SHORT = 3'h4;
	localparam logic [2:0] SEL_SHORT_ALT = 3'h5;
	localparam logic [2:0] SEL_CUSTOM = 3'h7;
	localparam logic [15:0] PRESET_ZERO = 16'h0000;
	localparam logic [15:0] PRESET_A = 16'h6363;
	localparam logic [15:0] PRESET_ALT = 16'hA671;
	localparam logic [15:0] PRESET_B = 16'hFFFF;
	localparam logic [15:0] PRESET_SHORT = 16'h0012;
	localparam logic [15:0] PRESET_SHORT_ALT = 16'hE012;
	localparam logic [15:0] CRC16_POLY = 16'h8408;
	localparam logic [4:0] CRC5_POLY = 5'h12;
	localparam logic [15:0] CRC16_RESIDUE = 16'h0000;
	localparam logic [15:0] CRC16_RESIDUE_INV = 16'hF0B8;
	localparam logic [4:0] CRC5_RESIDUE = 5'h00;
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {PROTO_A, PROTO_B, PROTO_JIS_212, PROTO_JIS_424} proto_t;

	// reserved selector code loads zero
	function automatic logic [15:0] preset_decode(input logic [2:0] sel, input logic [15:0] custom);
		return (sel == SEL_A) ? PRESET_A :
			(sel == SEL_ALT) ? PRESET_ALT :
			(sel == SEL_B) ? PRESET_B :
			(sel == SEL_SHORT) ? PRESET_SHORT :
			(sel == SEL_SHORT_ALT) ? PRESET_SHORT_ALT :
			(sel == SEL_CUSTOM) ? custom : PRESET_ZERO;
	endfunction
endpackage

/* File: rtl/rx_guard_timer.sv */
`timescale 1ns/1ps
module rx_guard_timer #(
	parameter int RELOAD_W = 20,
	parameter int PRESC_W = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic start_in,
	input wire logic [RELOAD_W-1:0] reload_in,
	input wire logic [PRESC_W-1:0] presc_in,
	output logic active_out,
	output logic expired_out
);
	initial begin
		if (RELOAD_W < 1 || PRESC_W < 1) begin
			$error("guard timer widths must be positive");
		end
	end

	logic [RELOAD_W-1:0] cnt_reg;
	logic [PRESC_W-1:0] pcnt_reg;
	logic exp_reg;
	wire tick = (pcnt_reg == '0);

	////////////////////////////////////////////////////////////////////////////
	// reload zero leaves the timer idle; one count per prescaler expiry
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
			pcnt_reg <= '0;
			exp_reg <= 1'b0;
		end else if (ce_in) begin
			exp_reg <= 1'b0;
			if (start_in) begin
				cnt_reg <= reload_in;
				pcnt_reg <= presc_in;
			end else if (cnt_reg != '0) begin
				if (tick) begin
					pcnt_reg <= presc_in;
					cnt_reg <= cnt_reg - 1'b1;
					exp_reg <= (cnt_reg == 1);
				end else begin
					pcnt_reg <= pcnt_reg - 1'b1;
				end
			end
		end
	end

	assign active_out = (cnt_reg != '0);
	assign expired_out = exp_reg;
endmodule

/* File: rtl/rx_crc_unit.sv */
`timescale 1ns/1ps
module rx_crc_unit import rx_guard_crc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic load_in,
	input wire logic [15:0] preset_in,
	input wire logic five_in,
	input wire logic bit_valid_in,
	input wire logic bit_in,
	output logic [15:0] crc_out
);
	logic [15:0] crc_reg;

	////////////////////////////////////////////////////////////////////////////
	// lsb-first shift for both widths
	wire fb = crc_reg[0] ^ bit_in;
	wire [15:0] next16 = {1'b0, crc_reg[15:1]} ^ (fb ? CRC16_POLY : 16'h0000);
	wire [4:0] next5 = {1'b0, crc_reg[4:1]} ^ (fb ? CRC5_POLY : 5'h00);
	wire [15:0] load_val = five_in ? {8'h00, preset_in[7:0]} : preset_in;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			crc_reg <= 16'h0000;
		end else if (ce_in) begin
			if (load_in) begin
				crc_reg <= load_val;
			end else if (bit_valid_in) begin
				crc_reg <= five_in ? {11'h000, next5} : next16;
			end
		end
	end

	assign crc_out = crc_reg;
endmodule

/* File: test/rf_peer_model.sv */
`timescale 1ns/1ps
module rf_peer_model (
	input wire logic clk_in,
	output logic tx_end_out,
	output logic rx_start_out,
	output logic bit_valid_out,
	output logic bit_out,
	output logic coll_out,
	output logic rx_end_out
);
	logic [2:0] ctl_reg = 3'h0;
	initial begin
		bit_valid_out = 1'b0;
		bit_out = 1'b0;
		coll_out = 1'b0;
	end
	assign tx_end_out = ctl_reg[0];
	assign rx_start_out = ctl_reg[1];
	assign rx_end_out = ctl_reg[2];
	////////////////////////////////////////////////////////////////////////////
	// one-cycle pulse: 0 transmit end, 1 receive start, 2 frame end
	task automatic pulse(input int k);
		@(posedge clk_in);
		ctl_reg[k] <= 1'b1;
		@(posedge clk_in);
		ctl_reg[k] <= 1'b0;
	endtask
	// back-to-back bit strobes, lsb first; only bit c flagged collided
	task automatic send(input logic [31:0] d, input int n, input int c);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			bit_valid_out <= 1'b1;
			bit_out <= d[i];
			coll_out <= (i == c);
		end
		@(posedge clk_in);
		bit_valid_out <= 1'b0;
		bit_out <= ~d[n-1];
		coll_out <= 1'b0;
	endtask
endmodule

/* File: test/rx_guard_crc_top_tb.sv */
`timescale 1ns/1ps
module rx_guard_crc_top_tb import rx_guard_crc_pkg::*; ();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hwrite = 1'b0;
	logic det_v = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b1;
	logic [1:0] htrans = 2'h0;
	logic [9:0] haddr = 10'h000;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] rd;
	proto_t det_p = PROTO_A;
	wire logic hready, hresp, crc_ok, g_act, irq, bv, tx_end, rx_start, bvalid, bval, coll, rx_end;
	wire logic [7:0] rbyte;
	wire logic [31:0] hrdata;
	int num_errors = 0;
	int num_checks = 0;
	int nbytes = 0;
	int gcnt = 0;
	int g0, b0;
	logic [7:0] last_b = 8'h00;
	logic [15:0] c;
	logic [15:0] pre [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF, 16'h0012, 16'hE012,
		16'h0000, 16'hBEEF};
	logic [31:0] det_tab [4] = '{32'h00000C08, 32'h0000001B, 32'h00000001, 32'h00000001};
	logic [7:0] rst_idx [5] = '{IDX_GUARD_CFG, IDX_CRC_CFG, IDX_IRQ_MASK, IDX_CTRL, IDX_STATUS};

	initial begin
		forever #4 clk = ~clk;
	end

	rf_peer_model rf_peer_model_inst (.clk_in(clk), .tx_end_out(tx_end), .rx_start_out(rx_start),
		.bit_valid_out(bvalid), .bit_out(bval), .coll_out(coll), .rx_end_out(rx_end));

	rx_guard_crc_top rx_guard_crc_top_inst (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
		.HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
		.HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HREADYOUT_OUT(hready),
		.HRESP_OUT(hresp), .HRDATA_OUT(hrdata), .TX_END_IN(tx_end), .RX_START_IN(rx_start),
		.RX_BIT_VALID_IN(bvalid), .RX_BIT_IN(bval), .RX_COLL_IN(coll), .RX_END_IN(rx_end),
		.MODE_DET_VALID_IN(det_v), .MODE_DET_PROTO_IN(det_p), .RX_BYTE_OUT(rbyte),
		.RX_BYTE_VALID_OUT(bv), .RX_CRC_OK_OUT(crc_ok), .GUARD_ACTIVE_OUT(g_act), .IRQ_OUT(irq));

	always @(posedge clk) begin
		if (bv === 1'b1) begin
			nbytes <= nbytes + 1;
			last_b <= rbyte;
		end
		if (g_act === 1'b1) begin
			gcnt <= gcnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic rdy();
		int n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 100) begin
				num_errors++;
				close_out();
			end
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {idx, 2'b00};
		hwrite <= w;
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h00000000);
		check(name, rd, exp);
	endtask
	task automatic rx(input logic [31:0] d, input int n, input int k);
		rf_peer_model_inst.pulse(1);
		rf_peer_model_inst.send(d, n, k);
		rf_peer_model_inst.pulse(2);
		repeat (3) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		close_out();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rst_idx[i]) rd_chk("reset", rst_idx[i], 32'h00000000);
		check("hresp", hresp, 1'b0);
		// clock enable low and a deselected bus both leave registers alone
		ce <= 1'b0;
		bus(1'b1, IDX_GUARD_CFG, 32'hFFFFFFFF);
		ce <= 1'b1;
		rd_chk("ce_freeze", IDX_GUARD_CFG, 32'h00000000);
		hsel <= 1'b0;
		bus(1'b1, IDX_CRC_CFG, 32'hFFFFFFFF);
		hsel <= 1'b1;
		rd_chk("hsel_off", IDX_CRC_CFG, 32'h00000000);
		bus(1'b1, IDX_GUARD_CFG, 32'hFFFFFFFF);
		rd_chk("guard_cfg", IDX_GUARD_CFG, 32'h0FFFFFFF);
		bus(1'b1, IDX_CRC_CFG, 32'hFFFFFFFF);
		rd_chk("crc_cfg", IDX_CRC_CFG, 32'hFFFF0FFF);
		bus(1'b1, 8'h30, 32'hFFFFFFFF);
		rd_chk("unmapped", 8'h30, 32'h00000000);
		bus(1'b1, IDX_GUARD_CFG, 32'h00000000);
		// parity, collision and first bit slot
		bus(1'b1, IDX_CRC_CFG, 32'h00000400);
		rx(32'h000001A5, 9, -1);
		check("par_byte", last_b, 8'hA5);
		rd_chk("par_even_err", IDX_STATUS, 32'h00000001);
		bus(1'b1, IDX_CRC_CFG, 32'h00000C00);
		rx(32'h000001A5, 9, -1);
		rd_chk("par_odd_ok", IDX_STATUS, 32'h00000000);
		bus(1'b1, IDX_CRC_CFG, 32'h00000000);
		rx(32'h000000FF, 8, 4);
		check("coll_clear", last_b, 8'h0F);
		bus(1'b1, IDX_CRC_CFG, 32'h00000200);
		rx(32'h000000FF, 8, 4);
		check("coll_keep", last_b, 8'hFF);
		bus(1'b1, IDX_CRC_CFG, 32'h000000C0);
		rx(32'h00000016, 5, -1);
		check("slot", last_b[7:3], 5'h16);
		// every preset code, inverted residue on odd codes
		for (int s = 0; s < 8; s++) begin
			bus(1'b1, IDX_CRC_CFG, {16'hBEEF, 10'h000, s[2:0], 1'b0, s[0], 1'b1});
			c = crc16(crc16(pre[s], 8'h12), 8'h34);
			if (s[0]) c = ~c;
			rx({c, 16'h3412}, 32, -1);
			check("crc_ok", crc_ok, 1'b1);
		end
		rx(32'h0000FF12, 24, -1);
		check("crc_bad", crc_ok, 1'b0);
		rd_chk("crc_err", IDX_STATUS, 32'h00000001);
		// 5-bit crc seeded from the low byte of a preset whose high byte is set
		bus(1'b1, IDX_CRC_CFG, 32'h0000002D);
		c[4:0] = crc5(pre[5][4:0], 8'h34);
		rx({19'h00000, c[4:0], 8'h34}, 13, -1);
		check("crc5_ok", crc_ok, 1'b1);
		rx({19'h00000, ~c[4:0], 8'h34}, 13, -1);
		check("crc5_bad", crc_ok, 1'b0);
		// guard timer, refused frame, interrupt
		bus(1'b1, IDX_IRQ_MASK, 32'h00000004);
		bus(1'b1, IDX_GUARD_CFG, 32'h0000027F);
		bus(1'b0, IDX_IRQ_STATUS, 32'h00000000);
		g0 = gcnt;
		b0 = nbytes;
		rf_peer_model_inst.pulse(0);
		rd_chk("stat_guard", IDX_STATUS, 32'h00000003);
		rx(32'h000000A5, 8, -1);
		repeat (300) @(posedge clk);
		check("guard_len", gcnt - g0, 256);
		check("guard_drop", nbytes, b0);
		check("irq_on", irq, 1'b1);
		bus(1'b0, IDX_IRQ_STATUS, 32'h00000000);
		check("irq_guard", rd[2], 1'b1);
		check("irq_off", irq, 1'b0);
		bus(1'b1, IDX_GUARD_CFG, 32'h0000007F);
		g0 = gcnt;
		rf_peer_model_inst.pulse(0);
		repeat (10) @(posedge clk);
		check("guard_zero", gcnt, g0);
		// mode detector, disabled then enabled
		for (int a = 0; a < 2; a++) begin
			bus(1'b1, IDX_CTRL, a);
			for (int p = 0; p < 4; p++) begin
				bus(1'b1, IDX_CRC_CFG, 32'h00000000);
				@(posedge clk);
				det_v <= 1'b1;
				det_p <= proto_t'(p);
				@(posedge clk);
				det_v <= 1'b0;
				rd_chk("detect", IDX_CRC_CFG, a ? det_tab[p] : 32'h0);
			end
		end
		close_out();
	end

	function automatic logic [15:0] crc16(input logic [15:0] v, input logic [7:0] b);
		for (int i = 0; i < 8; i++) v = (v[0] ^ b[i]) ? ((v >> 1) ^ 16'h8408) : (v >> 1);
		return v;
	endfunction
	function automatic logic [4:0] crc5(input logic [4:0] v, input logic [7:0] b);
		for (int i = 0; i < 8; i++) v = (v[0] ^ b[i]) ? ((v >> 1) ^ CRC5_POLY) : (v >> 1);
		return v;
	endfunction
endmodule
